// ==== core/flash_host_pkg.sv ====
// constants and carriers for the flash command host controller
// assumes an asynchronous flash on an 8-bit command/status bus
package flash_host_pkg;
  // command bytes
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_WRITE_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME        = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
  localparam logic [7:0] CMD_SET_LOCK_CONF = 8'h01;
  localparam logic [7:0] CMD_CLR_LOCK_CONF = 8'hD0;
  // status bit positions
  localparam int SR_READY     = 7;
  localparam int SR_ERASE_SUS = 6;
  localparam int SR_EC_ERR    = 5;
  localparam int SR_WS_ERR    = 4;
  localparam int SR_VPP_LOW   = 3;
  localparam int SR_WRITE_SUS = 2;
  localparam int SR_PROTECT   = 1;
  // bus timing in ns at 100 MHz core clock
  localparam int CLK_NS       = 10;
  localparam int WE_LOW_NS    = 50;
  localparam int OE_ACCESS_NS = 100;
  localparam int WE_CYC       = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_CYC       = (OE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 4;

  typedef enum logic [2:0] {
    OP_ERASE_SUSPEND,
    OP_ERASE_RESUME,
    OP_WRITE_SUSPEND,
    OP_WRITE_RESUME,
    OP_SET_LOCK,
    OP_CLEAR_LOCKS,
    OP_CLEAR_STATUS,
    OP_READ_STATUS
  } op_e;

  typedef struct packed {
    op_e         op;
    logic [20:0] addr;
  } req_s;

  typedef struct packed {
    logic       done;
    logic       error;
    logic       protect;
    logic       vpp_low;
    logic       locks_unknown;
    logic [7:0] status;
  } rsp_s;
endpackage

// ==== core/flash_bus_cycle.sv ====
// one flash bus cycle: a command write or a status read
// assumes async flash pins; data in already synchronised by caller
`timescale 1ns/10ps
module flash_bus_cycle #(
  parameter int WE_CYC = flash_host_pkg::WE_CYC,
  parameter int OE_CYC = flash_host_pkg::OE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        is_read,
  input  wire logic [20:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  dq_sync,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata,
  output logic [20:0]      fa,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  output logic             we_n,
  output logic             oe_n
);
  localparam int CW = flash_host_pkg::CNT_W;
  initial begin
    if (WE_CYC < 1 || OE_CYC < 1 || WE_CYC >= 2**CW || OE_CYC + 2 >= 2**CW)
      $error("bus cycle counts out of range");
  end

  logic [CW-1:0] cnt_reg;
  logic          rd_reg;

  // ----------------------------------------
  // strobe sequencing
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      cnt_reg <= '0;
      rd_reg  <= 1'b0;
      we_n    <= 1'b1;
      oe_n    <= 1'b1;
      dq_oe   <= 1'b0;
      dq_out  <= 8'h00;
      fa      <= '0;
      rdata   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy    <= 1'b1;
        rd_reg  <= is_read;
        fa      <= addr;
        dq_out  <= wdata;
        dq_oe   <= !is_read;
        we_n    <= is_read;
        oe_n    <= !is_read;
        // reads wait two more edges for the input synchroniser
        cnt_reg <= is_read ? CW'(OE_CYC + 2) : CW'(WE_CYC);
      end else if (busy) begin
        if (cnt_reg > CW'(1)) begin
          cnt_reg <= cnt_reg - CW'(1);
        end else begin
          busy  <= 1'b0;
          done  <= 1'b1;
          we_n  <= 1'b1;
          oe_n  <= 1'b1;
          dq_oe <= 1'b0;
          if (rd_reg) begin
            rdata <= dq_sync;
          end
        end
      end
    end
  end

  chk_strobes_apart: assert property (@(posedge core_clk) disable iff (rst)
    !(!we_n && !oe_n)) else $error("write and read strobes overlap");
endmodule

// ==== core/flash_cmd_host.sv ====
// host-side command sequencer: suspend/resume and lock-bit commands
// assumes flash status on dq, one sts pin, all pins asynchronous
// Functional notes
// - only legal commands issued during erase suspend
// - host holds reset, protect, width steady; write_protect_n follows protect_level, not held
// - only reads and resume during write suspend
// - host holds reset, protect, width on resume; write_protect_n follows protect_level, not held
// - set-lock is setup then confirm in block
// - after set-lock check bit4, clear status
// - after clear-locks check bit5, clear status
// - aborted clear-locks leaves locks unknown
`timescale 1ns/10ps
module flash_cmd_host (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 req_valid,
  input  wire flash_host_pkg::req_s req,
  input  wire logic                 protect_level,
  input  wire logic                 byte_mode,
  output logic                      req_ready,
  output flash_host_pkg::rsp_s      rsp,
  output logic                      erase_suspended,
  output logic                      write_suspended,
  output logic [20:0]               fa,
  output logic [7:0]                dq_out,
  output logic                      dq_oe,
  input  wire logic [7:0]           dq_in,
  output logic                      ce_n,
  output logic                      we_n,
  output logic                      oe_n,
  output logic                      reset_powerdown_n,
  output logic                      write_protect_n,
  output logic                      byte_width_n,
  input  wire logic                 status_output_pin
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD1, ST_CMD2, ST_POLL, ST_WAIT, ST_DONE
  } state_e;

  state_e                state_reg;
  flash_host_pkg::req_s  cur_reg;
  logic [7:0]            dq_meta_reg;
  logic [7:0]            dq_sync_reg;
  logic                  sts_meta_reg;
  logic                  sts_sync_reg;
  logic                  bus_start;
  logic                  bus_read;
  logic [7:0]            bus_wdata;
  logic                  bus_busy;
  logic                  bus_done;
  logic [7:0]            bus_rdata;
  logic                  two_cycle;
  logic [7:0]            first_byte;
  logic [7:0]            second_byte;
  logic                  es_reg;
  logic                  ws_reg;
  logic                  nested_write_reg;
  logic                  locks_unknown_reg;
  logic                  clr_lock_active_reg;
  logic                  latched_byte_reg;
  logic                  legal;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_meta_reg  <= 8'h00;
      dq_sync_reg  <= 8'h00;
      sts_meta_reg <= 1'b1;
      sts_sync_reg <= 1'b1;
    end else begin
      dq_meta_reg  <= dq_in;
      dq_sync_reg  <= dq_meta_reg;
      sts_meta_reg <= status_output_pin;
      sts_sync_reg <= sts_meta_reg;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  always_comb begin
    two_cycle   = 1'b0;
    first_byte  = flash_host_pkg::CMD_READ_STATUS;
    second_byte = flash_host_pkg::CMD_READ_STATUS;
    case (cur_reg.op)
      flash_host_pkg::OP_ERASE_SUSPEND:
        first_byte = flash_host_pkg::CMD_ERASE_SUSPEND;
      flash_host_pkg::OP_WRITE_SUSPEND:
        first_byte = flash_host_pkg::CMD_WRITE_SUSPEND;
      flash_host_pkg::OP_ERASE_RESUME,
      flash_host_pkg::OP_WRITE_RESUME:
        first_byte = flash_host_pkg::CMD_RESUME;
      flash_host_pkg::OP_SET_LOCK: begin
        two_cycle   = 1'b1;
        first_byte  = flash_host_pkg::CMD_LOCK_SETUP;
        second_byte = flash_host_pkg::CMD_SET_LOCK_CONF;
      end
      flash_host_pkg::OP_CLEAR_LOCKS: begin
        two_cycle   = 1'b1;
        first_byte  = flash_host_pkg::CMD_LOCK_SETUP;
        second_byte = flash_host_pkg::CMD_CLR_LOCK_CONF;
      end
      flash_host_pkg::OP_CLEAR_STATUS:
        first_byte = flash_host_pkg::CMD_CLEAR_STATUS;
      default:
        first_byte = flash_host_pkg::CMD_READ_STATUS;
    endcase
  end

  // only what the flash accepts in the current suspend state
  always_comb begin
    legal = 1'b1;
    if (ws_reg) begin
      legal = (req.op == flash_host_pkg::OP_WRITE_RESUME) ||
              (req.op == flash_host_pkg::OP_READ_STATUS);
    end else if (es_reg) begin
      legal = (req.op == flash_host_pkg::OP_ERASE_RESUME && !nested_write_reg)
           || (req.op == flash_host_pkg::OP_WRITE_SUSPEND)
           || (req.op == flash_host_pkg::OP_READ_STATUS);
    end else begin
      legal = (req.op != flash_host_pkg::OP_ERASE_RESUME) &&
              (req.op != flash_host_pkg::OP_WRITE_RESUME);
    end
  end

  assign req_ready = (state_reg == ST_IDLE) && legal;
  assign bus_start = (state_reg == ST_CMD1 || state_reg == ST_CMD2 ||
                      state_reg == ST_POLL) && !bus_busy && !bus_done;
  assign bus_read  = (state_reg == ST_POLL);
  assign bus_wdata = (state_reg == ST_CMD2) ? second_byte : first_byte;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cur_reg   <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: if (req_valid && req_ready) begin
          cur_reg   <= req;
          state_reg <= (req.op == flash_host_pkg::OP_READ_STATUS) ?
                       ST_POLL : ST_CMD1;
        end
        ST_CMD1: if (bus_done) begin
          state_reg <= two_cycle ? ST_CMD2 : ST_POLL;
        end
        ST_CMD2: if (bus_done) begin
          state_reg <= ST_POLL;
        end
        // busy shown on sts low; poll status once it releases
        ST_POLL: if (bus_done) begin
          state_reg <= bus_rdata[flash_host_pkg::SR_READY] ?
                       ST_DONE : ST_WAIT;
        end
        ST_WAIT: if (sts_sync_reg) begin
          state_reg <= ST_POLL;
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // suspend tracking and lock state
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      es_reg              <= 1'b0;
      ws_reg              <= 1'b0;
      nested_write_reg    <= 1'b0;
      clr_lock_active_reg <= 1'b0;
      locks_unknown_reg   <= 1'b0;
    end else begin
      if (state_reg == ST_POLL && bus_done) begin
        es_reg <= bus_rdata[flash_host_pkg::SR_ERASE_SUS];
        ws_reg <= bus_rdata[flash_host_pkg::SR_WRITE_SUS];
        // busy while erase suspended means a nested write runs
        nested_write_reg <= bus_rdata[flash_host_pkg::SR_ERASE_SUS] &&
                            !bus_rdata[flash_host_pkg::SR_READY];
      end
      if (state_reg == ST_CMD2 && cur_reg.op ==
          flash_host_pkg::OP_CLEAR_LOCKS) begin
        clr_lock_active_reg <= 1'b1;
        locks_unknown_reg   <= 1'b1;
      end else if (state_reg == ST_POLL && bus_done && clr_lock_active_reg &&
                   bus_rdata[flash_host_pkg::SR_READY]) begin
        clr_lock_active_reg <= 1'b0;
        locks_unknown_reg   <= bus_rdata[flash_host_pkg::SR_VPP_LOW];
      end
    end
  end

  // width level captured as a job starts outside any suspend
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latched_byte_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && req_valid && req_ready &&
                 !es_reg && !ws_reg) begin
      latched_byte_reg <= !byte_mode;
    end
  end

  // ----------------------------------------
  // answer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.done          <= (state_reg == ST_DONE);
      rsp.locks_unknown <= locks_unknown_reg;
      if (state_reg == ST_POLL && bus_done) begin
        rsp.status  <= bus_rdata;
        rsp.error   <= bus_rdata[flash_host_pkg::SR_WS_ERR] ||
                       bus_rdata[flash_host_pkg::SR_EC_ERR];
        rsp.protect <= bus_rdata[flash_host_pkg::SR_PROTECT];
        rsp.vpp_low <= bus_rdata[flash_host_pkg::SR_VPP_LOW];
      end
    end
  end

  assign erase_suspended   = es_reg;
  assign write_suspended   = ws_reg;
  assign ce_n              = 1'b0;
  assign reset_powerdown_n = 1'b1;
  // width held while suspended; protect follows protect_level
  assign write_protect_n   = protect_level;
  assign byte_width_n      = (es_reg || ws_reg) ? latched_byte_reg
                                                : !byte_mode;

  flash_bus_cycle u_bus (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (bus_start),
    .is_read  (bus_read),
    .addr     (cur_reg.addr),
    .wdata    (bus_wdata),
    .dq_sync  (dq_sync_reg),
    .busy     (bus_busy),
    .done     (bus_done),
    .rdata    (bus_rdata),
    .fa       (fa),
    .dq_out   (dq_out),
    .dq_oe    (dq_oe),
    .we_n     (we_n),
    .oe_n     (oe_n)
  );

  chk_suspend_legal: assert property (@(posedge core_clk) disable iff (rst)
    (req_valid && req_ready && ws_reg) |->
      req.op inside {flash_host_pkg::OP_WRITE_RESUME,
                     flash_host_pkg::OP_READ_STATUS})
    else $error("illegal command taken in write suspend");
  chk_resume_hold: assert property (@(posedge core_clk) disable iff (rst)
    (req_valid && req_ready && req.op == flash_host_pkg::OP_ERASE_RESUME)
      |-> es_reg && !nested_write_reg)
    else $error("erase resume while nested write busy");
  chk_lock_two: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == ST_CMD1 && bus_done && two_cycle) |=> state_reg == ST_CMD2)
    else $error("lock confirm not issued");
  chk_done_ready: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == ST_DONE) |-> rsp.status[flash_host_pkg::SR_READY])
    else $error("done without ready status");
  chk_reset_high: assert property (@(posedge core_clk) disable iff (rst)
    es_reg |-> reset_powerdown_n)
    else $error("reset pin driven during suspend");
  chk_width_kept: assert property (@(posedge core_clk) disable iff (rst)
    (ws_reg && $past(ws_reg)) |-> $stable(byte_width_n))
    else $error("width select changed in suspend");
  chk_error_flag: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == ST_POLL && bus_done && bus_rdata[flash_host_pkg::SR_EC_ERR])
      |=> rsp.error)
    else $error("error status not reported");
  chk_dq_release: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == ST_WAIT) |-> !dq_oe)
    else $error("dq driven while waiting");
endmodule

// ==== verif/flash_dev_model.sv ====
// behavioural flash device: status register, suspend and lock-bit commands
// assumes command writes end on we_n rising, sampled on core_clk
`timescale 1ns/10ps
module flash_dev_model #(
  parameter int RUN_CYC = 80,
  parameter int SUS_CYC = 12
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        start_erase,
  input  wire logic        start_write,
  input  wire logic        vpp_ok,
  input  wire logic [20:0] fa,
  input  wire logic [7:0]  dq_wr,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        wp_n,
  output logic [7:0]       dq_rd,
  output wire logic        sts
);
  logic [7:0]  sr;
  logic [31:0] locks;
  logic        we_q;
  logic [7:0]  dq_q;
  logic        setup;
  logic        job_wr;
  int          cnt;
  int          sus;
  int          er_left;
  int          wr_left;

  // released bus shows the inverse of the status byte
  assign dq_rd = oe_n ? ~sr : sr;
  assign sts   = (cnt != 0) ? 1'b0 : 1'bz;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sr <= 8'h80;
      locks <= '0;
      we_q <= 1'b1;
      dq_q <= 8'h00;
      setup <= 1'b0;
      job_wr <= 1'b0;
      cnt <= 0;
      sus <= 0;
      er_left <= 0;
      wr_left <= 0;
    end else begin
      we_q <= we_n;
      if (sus > 0) begin
        sus <= sus - 1;
        if (sus == 1) begin
          cnt <= 0;
          sr[7] <= 1'b1;
          if (job_wr) begin
            wr_left <= cnt;
            sr[2] <= 1'b1;
          end else begin
            er_left <= cnt;
            sr[6] <= 1'b1;
          end
        end
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) sr[7] <= 1'b1;
      end
      if (start_erase) begin
        cnt <= 2 * RUN_CYC;
        job_wr <= 1'b0;
        sr <= 8'h00;
      end
      if (start_write) begin
        cnt <= RUN_CYC;
        job_wr <= 1'b1;
        sr[7] <= 1'b0;
      end
      // data is taken while we_n is still low; the host releases dq with it
      dq_q <= dq_wr;
      if (!we_q && we_n) begin
        if (setup) begin
          setup <= 1'b0;
          if (dq_q != flash_host_pkg::CMD_SET_LOCK_CONF &&
              dq_q != flash_host_pkg::CMD_CLR_LOCK_CONF) begin
            sr <= 8'hB0;
          end else if (!wp_n) sr <= dq_q[0] ? 8'h92 : 8'hA2;
          else if (!dq_q[0] && !vpp_ok) sr <= 8'hA8;
          else begin
            sr <= 8'h00;
            cnt <= RUN_CYC;
            if (dq_q[0]) locks[fa[20:16]] <= 1'b1;
            else locks <= '0;
          end
        end else begin
          case (dq_q)
            flash_host_pkg::CMD_LOCK_SETUP: setup <= 1'b1;
            flash_host_pkg::CMD_CLEAR_STATUS: sr[5:1] <= 5'h00;
            flash_host_pkg::CMD_ERASE_SUSPEND: begin
              if (cnt > 0) sus <= SUS_CYC;
            end
            flash_host_pkg::CMD_RESUME: begin
              if (sr[2]) begin
                sr[2] <= 1'b0;
                sr[7] <= 1'b0;
                cnt <= wr_left;
                job_wr <= 1'b1;
              end else if (sr[6] && cnt == 0) begin
                sr[6] <= 1'b0;
                sr[7] <= 1'b0;
                cnt <= er_left;
                job_wr <= 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// testbench for the flash command host against a behavioural device
// assumes flash_host_pkg and flash_dev_model compiled before this file
`timescale 1ns/10ps
module tb_top;
  logic                 core_clk, rst, req_valid, protect_level, byte_mode;
  logic                 start_erase, start_write, vpp_ok, req_ready;
  logic                 erase_suspended, write_suspended, dq_oe, ce_n;
  logic                 we_n, oe_n, reset_powerdown_n, write_protect_n;
  logic                 byte_width_n;
  logic [20:0]          fa;
  logic [7:0]           dq_out, dq_rd, dq_bus;
  flash_host_pkg::req_s req;
  flash_host_pkg::rsp_s rsp;
  wire                  sts_w;
  int                   errors, n_tests;
  logic [7:0]           l_exp [5] = '{8'h80, 8'h92, 8'hA2, 8'hA8, 8'h80};
  logic [4:0]           l_set = 5'b00011, l_prot = 5'b11001;
  logic [4:0]           l_vpp = 5'b10111, l_lock = 5'b01111;

  pullup (sts_w);
  assign dq_bus = dq_oe ? dq_out : dq_rd;

  flash_cmd_host dut_u (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .protect_level(protect_level),
    .byte_mode(byte_mode), .req_ready(req_ready), .rsp(rsp),
    .erase_suspended(erase_suspended), .write_suspended(write_suspended),
    .fa(fa), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .reset_powerdown_n(reset_powerdown_n),
    .write_protect_n(write_protect_n), .byte_width_n(byte_width_n),
    .status_output_pin(sts_w));

  flash_dev_model model_u (.core_clk(core_clk), .rst(rst),
    .start_erase(start_erase), .start_write(start_write), .vpp_ok(vpp_ok),
    .fa(fa), .dq_wr(dq_bus), .we_n(we_n), .oe_n(oe_n),
    .wp_n(write_protect_n), .dq_rd(dq_rd), .sts(sts_w));

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // offers one request, holds it until taken, waits for its done pulse
  task automatic do_op(input flash_host_pkg::op_e op, input logic [20:0] a);
    int i;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req.op <= op;
    req.addr <= a;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 50);
    @(posedge core_clk);
    req_valid <= 1'b0;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (rsp.done !== 1'b1 && i < 3000);
    check("done", {7'h00, rsp.done}, 8'h01);
  endtask

  task automatic refused(input flash_host_pkg::op_e op);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req.op <= op;
    @(negedge core_clk);
    check("req_ready", {7'h00, req_ready}, 8'h00);
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask

  task automatic kick(input logic e, input logic w, input logic p,
                      input logic v);
    @(posedge core_clk);
    start_erase <= e;
    start_write <= w;
    protect_level <= p;
    vpp_ok <= v;
    @(posedge core_clk);
    start_erase <= 1'b0;
    start_write <= 1'b0;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #300000;
    errors++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    protect_level = 1'b1;
    byte_mode = 1'b1;
    start_erase = 1'b0;
    start_write = 1'b0;
    vpp_ok = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    refused(flash_host_pkg::OP_ERASE_RESUME);
    refused(flash_host_pkg::OP_WRITE_RESUME);
    $display("test idle refusals done");
    for (int i = 0; i < 5; i++) begin
      kick(1'b0, 1'b0, l_prot[i], l_vpp[i]);
      do_op(l_set[i] ? flash_host_pkg::OP_SET_LOCK :
            flash_host_pkg::OP_CLEAR_LOCKS, 21'h050000);
      check("status", rsp.status, l_exp[i]);
      check("flags",
            {5'h00, rsp.error, rsp.protect, rsp.vpp_low},
            {5'h00, l_exp[i][5] | l_exp[i][4], l_exp[i][1], l_exp[i][3]});
      check("lock", {7'h00, model_u.locks[5]},
            {7'h00, l_lock[i]});
      check("unknown", {7'h00, rsp.locks_unknown},
            {7'h00, !l_set[i] & l_exp[i][3]});
      do_op(flash_host_pkg::OP_CLEAR_STATUS, 21'h000000);
      check("cleared", rsp.status, 8'h80);
    end
    $display("test lock bits done");
    kick(1'b1, 1'b0, 1'b1, 1'b1);
    do_op(flash_host_pkg::OP_ERASE_SUSPEND, 21'h030000);
    check("status", rsp.status, 8'hC0);
    check("susp", {6'h00, erase_suspended, write_suspended}, 8'h02);
    check("pins",
          {5'h00, reset_powerdown_n, byte_width_n, write_protect_n}, 8'h05);
    refused(flash_host_pkg::OP_SET_LOCK);
    kick(1'b0, 1'b1, 1'b1, 1'b1);
    do_op(flash_host_pkg::OP_WRITE_SUSPEND, 21'h040000);
    check("status", rsp.status, 8'hC4);
    refused(flash_host_pkg::OP_ERASE_RESUME);
    do_op(flash_host_pkg::OP_WRITE_RESUME, 21'h040000);
    check("status", rsp.status, 8'hC0);
    do_op(flash_host_pkg::OP_ERASE_RESUME, 21'h030000);
    check("status", rsp.status, 8'h80);
    check("susp", {6'h00, erase_suspended, write_suspended}, 8'h00);
    $display("test erase suspend done");
    kick(1'b0, 1'b1, 1'b1, 1'b1);
    do_op(flash_host_pkg::OP_WRITE_SUSPEND, 21'h060000);
    check("status", rsp.status, 8'h84);
    check("susp", {6'h00, erase_suspended, write_suspended}, 8'h01);
    check("pins",
          {5'h00, reset_powerdown_n, byte_width_n, write_protect_n}, 8'h05);
    refused(flash_host_pkg::OP_CLEAR_LOCKS);
    byte_mode <= 1'b0;
    @(posedge core_clk);
    check("width", {7'h00, byte_width_n}, 8'h00);
    byte_mode <= 1'b1;
    do_op(flash_host_pkg::OP_WRITE_RESUME, 21'h060000);
    check("status", rsp.status, 8'h80);
    check("susp", {6'h00, erase_suspended, write_suspended}, 8'h00);
    $display("test write suspend done");
    complete_run();
  end
endmodule
